// [dv/oscillator_sleep_run_control_tb.sv]
`timescale 1ns/1ps
module oscillator_sleep_run_control_tb;
   import osr_pkg::*;
   localparam int N = OSR_NUM_OSC;
   logic aclk = 1'h0, aresetn = 1'h0, async_clk = 1'h0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = '0, rdata, rd;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, pll_ref_select, resp;
   logic [1:0] sleep_mode = OSR_MODE_IDLE;
   logic [N-1:0] want = '0, periph_request, osc_ready, osc_run, async_enable;
   logic debug_halted = 1'h0, debugger_access = 1'h0, cold = 1'h0, bod_req = 1'h0, slow = 1'h0;
   logic mi, mo, si, so, bod_rst, irq, wake;
   logic [7:0] pll_ref_divider;
   int n_fail = 0, comparisons = 0;
   // =====
   // clocks, design and far side
   initial forever #4 aclk = ~aclk;
   initial forever #6.5 async_clk = ~async_clk;
   osr_ctrl #(.N(N)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_mode(sleep_mode),
      .periph_request(periph_request), .osc_ready(osc_ready), .debug_halted(debug_halted),
      .debugger_access(debugger_access), .debugger_cold_plug(cold), .brownout_3v3_reset_req(bod_req),
      .async_domain_clk(async_clk), .osc_run(osc_run), .main_osc_input_pin_own(mi),
      .main_osc_output_pin_own(mo), .slow_osc_input_pin_own(si), .slow_osc_output_pin_own(so),
      .pll_ref_select(pll_ref_select), .pll_ref_divider(pll_ref_divider), .async_enable(async_enable),
      .brownout_3v3_reset(bod_rst), .irq(irq), .wake_request(wake));
   osr_periph_model #(.N(N)) u_periph (.aclk(aclk), .aresetn(aresetn), .want(want), .slow(slow),
      .osc_run(osc_run), .periph_request(periph_request), .osc_ready(osc_ready));
   // =====
   // shared tasks
   task automatic summarize;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc
   // handshakes are judged just before the edge that completes them
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ah, wh, got;
      got = 1'h0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (int k = 0; k < 64 && !got; k++) begin
         @(negedge aclk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         got = bvalid;
         resp = bresp;
         @(posedge aclk);
         if (ah) awvalid <= 1'h0;
         if (wh) wvalid <= 1'h0;
      end
      bready <= 1'h0;
      if (!got) begin
         n_fail++;
         summarize();
      end
   endtask : wr
   task automatic rdw(input logic [7:0] a);
      logic ah, got;
      got = 1'h0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (int k = 0; k < 64 && !got; k++) begin
         @(negedge aclk);
         ah = arvalid && arready;
         got = rvalid;
         rd = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ah) arvalid <= 1'h0;
      end
      rready <= 1'h0;
      if (!got) begin
         n_fail++;
         summarize();
      end
   endtask : rdw
   function automatic logic [31:0] ctl(input logic en, input logic sb, input logic od, input logic xt);
      ctl = '0;
      ctl[OSR_BIT_ENABLE] = en;
      ctl[OSR_BIT_RUN_IN_STANDBY] = sb;
      ctl[OSR_BIT_RUN_ON_REQUEST] = od;
      ctl[OSR_BIT_XTAL_MODE] = xt;
   endfunction : ctl
   // expected run level worked out from the sleep behaviour table
   function automatic logic exp_run(input int i, input logic stb, input logic en, input logic od,
      input logic sb, input logic q);
      if (!en) return 1'h0;
      if (stb && (!sb || i == OSR_IDX_FLL || i == OSR_IDX_PLL)) return 1'h0;
      return od ? q : 1'h1;
   endfunction : exp_run
   // =====
   // scenarios
   task automatic t_reset;
      for (int i = 0; i < N; i++) begin
         rdw(8'(4 * i));
         chk(rd, ctl(1'h0, 1'h0, 1'h1, 1'h0));
      end
      chk(32'(osc_run), 32'h1 << OSR_IDX_ULP_32K);
   endtask : t_reset
   // every enable, request and standby setting for a crystal and a locked loop
   task automatic t_table;
      logic [5:0] c;
      int i;
      for (int n = 0; n < 64; n++) begin
         c = 6'(n);
         i = c[5] ? OSR_IDX_FLL : OSR_IDX_MAIN_XTAL;
         wr(8'(4 * i), ctl(c[3], c[1], c[2], 1'h0));
         sleep_mode <= c[4] ? OSR_MODE_STANDBY : OSR_MODE_IDLE;
         want <= {N{c[0]}};
         cyc(6);
         chk(32'(osc_run[i]), 32'(exp_run(i, c[4], c[3], c[2], c[1], c[0])));
         chk(32'(osc_run[OSR_IDX_ULP_32K]), 32'h1);
      end
      sleep_mode <= OSR_MODE_IDLE;
      want <= '0;
   endtask : t_table
   task automatic t_pins;
      for (int n = 0; n < 4; n++) begin
         wr(n[1] ? 8'h04 : 8'h00, ctl(1'h1, 1'h0, 1'h0, n[0]));
         cyc(3);
         chk(32'(n[1] ? {si, so} : {mi, mo}), 32'({1'h1, n[0]}));
         wr(n[1] ? 8'h04 : 8'h00, 32'h0);
         cyc(3);
         chk(32'(n[1] ? {si, so} : {mi, mo}), 32'h0);
      end
   endtask : t_pins
   task automatic t_pll;
      logic [31:0] v;
      wr(8'h04, ctl(1'h1, 1'h0, 1'h0, 1'h1));
      for (int k = 0; k < 3; k++) begin
         v = {16'h0, 8'(8'h3c + k), 6'h0, 2'(k)};
         wr(OSR_OFF_PLL_REF, v);
         cyc(2);
         chk(32'({pll_ref_divider, 6'h0, pll_ref_select}), 32'(v[15:0]));
      end
   endtask : t_pll
   task automatic t_prot;
      wr(OSR_OFF_PROTECT, 32'h1);
      wr(8'h10, ctl(1'h1, 1'h0, 1'h0, 1'h0));
      chk(32'(resp), 32'(OSR_RESP_SLVERR));
      rdw(8'h10);
      chk(rd, ctl(1'h0, 1'h0, 1'h1, 1'h0));
      wr(OSR_OFF_INT_FLAGS, 32'h0);
      chk(32'(resp), 32'(OSR_RESP_OKAY));
      debug_halted <= 1'h1;
      cyc(4);
      wr(8'h10, ctl(1'h1, 1'h0, 1'h0, 1'h0));
      chk(32'(resp), 32'(OSR_RESP_OKAY));
      debug_halted <= 1'h0;
      debugger_access <= 1'h1;
      cyc(4);
      wr(8'h10, ctl(1'h0, 1'h0, 1'h1, 1'h0));
      chk(32'(resp), 32'(OSR_RESP_OKAY));
      wr(OSR_OFF_PROTECT, 32'h0);
      debugger_access <= 1'h0;
      rdw(8'h3c);
      chk({rd[29:0], resp}, 32'(OSR_RESP_SLVERR));
   endtask : t_prot
   // a slowly settling oscillator raises a flag; masked, then enabled, then cleared
   task automatic t_irq;
      wr(OSR_OFF_INT_FLAGS, 32'h7f);
      slow <= 1'h1;
      wr(8'h08, ctl(1'h1, 1'h0, 1'h0, 1'h0));
      cyc(12);
      rdw(OSR_OFF_INT_FLAGS);
      chk(rd, 32'h04);
      chk(32'(irq), 32'h0);
      chk(32'(async_enable), 32'h26);
      wr(OSR_OFF_INT_ENABLE, 32'h04);
      cyc(2);
      chk(32'({irq, wake}), 32'h3);
      wr(OSR_OFF_INT_FLAGS, 32'h0);
      rdw(OSR_OFF_INT_FLAGS);
      chk(rd, 32'h04);
      wr(OSR_OFF_INT_FLAGS, 32'h04);
      rdw(OSR_OFF_INT_FLAGS);
      chk(rd, 32'h0);
      chk(32'({irq, wake}), 32'h0);
   endtask : t_irq
   task automatic t_bod;
      bod_req <= 1'h1;
      cyc(6);
      chk(32'(bod_rst), 32'h1);
      cold <= 1'h1;
      cyc(6);
      chk(32'(bod_rst), 32'h0);
      cold <= 1'h0;
      bod_req <= 1'h0;
   endtask : t_bod
   // =====
   // main sequence
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      cyc(4);
      t_reset();
      t_table();
      t_pins();
      t_pll();
      t_prot();
      t_irq();
      t_bod();
      summarize();
   end
endmodule : oscillator_sleep_run_control_tb

// [dv/osr_ctrl_asserts.sv]
`timescale 1ns/1ps
// =====
// port-level checker of the oscillator run controller
module osr_ctrl_asserts
   import osr_pkg::*;
#(
   parameter int N = OSR_NUM_OSC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] sleep_mode,
   input wire logic debugger_cold_plug,
   input wire logic [N-1:0] osc_run,
   input wire logic main_osc_input_pin_own,
   input wire logic main_osc_output_pin_own,
   input wire logic slow_osc_input_pin_own,
   input wire logic slow_osc_output_pin_own,
   input wire logic brownout_3v3_reset,
   input wire logic irq,
   input wire logic wake_request
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // five samples cover both sync flops and the output flop
   sequence s_standby_held;
      (sleep_mode == OSR_MODE_STANDBY) [*5];
   endsequence
   sequence s_cold_held;
      debugger_cold_plug [*5];
   endsequence
   sequence s_both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   AST_ULP_ALWAYS_RUNS: assert property ($past(aresetn) |-> osc_run[OSR_IDX_ULP_32K])
      else $error("ultra low power oscillator stopped");
   AST_LOOPS_STOP_STANDBY: assert property (s_standby_held |-> !osc_run[OSR_IDX_FLL] && !osc_run[OSR_IDX_PLL])
      else $error("locked loop runs in standby");
   AST_XTAL_PINS: assert property (!(main_osc_output_pin_own && !main_osc_input_pin_own) &&
      !(slow_osc_output_pin_own && !slow_osc_input_pin_own))
      else $error("output pin taken without its input pin");
   AST_IRQ_WAKES: assert property (irq == wake_request)
      else $error("wake request differs from interrupt");
   AST_COLD_PLUG_MASK: assert property (s_cold_held |-> !brownout_3v3_reset)
      else $error("brownout reset not masked on cold plug");
   AST_WRITE_ANSWER: assert property (s_both_taken |=> ##1 s_axi_bvalid)
      else $error("write response missing");
   AST_BRESP_HOLDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   AST_RDATA_HOLDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
endmodule : osr_ctrl_asserts

bind osr_ctrl osr_ctrl_asserts #(.N(N)) u_asserts (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .sleep_mode(sleep_mode), .debugger_cold_plug(debugger_cold_plug), .osc_run(osc_run),
   .main_osc_input_pin_own(main_osc_input_pin_own), .main_osc_output_pin_own(main_osc_output_pin_own),
   .slow_osc_input_pin_own(slow_osc_input_pin_own), .slow_osc_output_pin_own(slow_osc_output_pin_own),
   .brownout_3v3_reset(brownout_3v3_reset), .irq(irq), .wake_request(wake_request));

// [dv/osr_periph_model.sv]
`timescale 1ns/1ps
// =====
// peripherals asking for clocks, and the ready lines of the oscillators
module osr_periph_model
   import osr_pkg::*;
#(
   parameter int N = OSR_NUM_OSC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [N-1:0] want,
   input wire logic slow,
   input wire logic [N-1:0] osc_run,
   output logic [N-1:0] periph_request,
   output logic [N-1:0] osc_ready
);
   logic [3:0][N-1:0] stage; // settling pipe of the run lines
   // requests follow the bench one edge late, like a real peripheral
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periph_request <= '0;
         stage <= '0;
      end else begin
         periph_request <= want;
         stage <= {stage[2:0], osc_run};
      end
   end
   // a slow oscillator settles in four cycles, else in one; ready falls the same delay after the run line
   assign osc_ready = slow ? stage[3] : stage[0];
endmodule : osr_periph_model

// [rtl/osr_ctrl.sv]
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module osr_ctrl
   import osr_pkg::*;
#(
   parameter int N = OSR_NUM_OSC
) (
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // system side
   input wire logic [1:0] sleep_mode,
   input wire logic [N-1:0] periph_request,
   input wire logic [N-1:0] osc_ready,
   input wire logic debug_halted,
   input wire logic debugger_access,
   input wire logic debugger_cold_plug,
   input wire logic brownout_3v3_reset_req,
   input wire logic async_domain_clk,
   output logic [N-1:0] osc_run,
   output logic main_osc_input_pin_own,
   output logic main_osc_output_pin_own,
   output logic slow_osc_input_pin_own,
   output logic slow_osc_output_pin_own,
   output logic [1:0] pll_ref_select,
   output logic [7:0] pll_ref_divider,
   output logic [N-1:0] async_enable,
   output logic brownout_3v3_reset,
   output logic irq,
   output logic wake_request
);
   // =====================================================================
   // pin and mode synchronisers
   // =====================================================================
   // everything below arrives from other domains; two flops each
   logic [N-1:0] req_s1, req_s2;
   logic [N-1:0] rdy_s1, rdy_s2;
   logic [1:0] mode_s1, mode_s2;
   logic [3:0] misc_s1, misc_s2; // halted, debugger, cold plug, brownout

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_s1 <= '0;
         req_s2 <= '0;
         rdy_s1 <= '0;
         rdy_s2 <= '0;
         mode_s1 <= OSR_MODE_ACTIVE;
         mode_s2 <= OSR_MODE_ACTIVE;
         misc_s1 <= 4'h0;
         misc_s2 <= 4'h0;
      end else begin
         req_s1 <= periph_request;
         req_s2 <= req_s1;
         rdy_s1 <= osc_ready;
         rdy_s2 <= rdy_s1;
         mode_s1 <= sleep_mode;
         mode_s2 <= mode_s1;
         misc_s1 <= {brownout_3v3_reset_req, debugger_cold_plug, debugger_access, debug_halted};
         misc_s2 <= misc_s1;
      end
   end
   // synchronised levels, by name
   wire halted = misc_s2[0];
   wire dbg_acc = misc_s2[1];
   wire cold_plug = misc_s2[2];
   wire bod_req = misc_s2[3];

   // =====================================================================
   // register state
   // =====================================================================
   logic [N-1:0] en_r; // enable per oscillator
   logic [N-1:0] od_r; // run_on_request
   logic [N-1:0] sb_r; // run_in_standby
   logic [N-1:0] xtal_r; // crystal mode (else external clock input)
   logic [1:0] ref_sel_r;
   logic [7:0] ref_div_r;
   // status flags and their enables
   logic [N-1:0] flags; // ready rise flags
   logic [N-1:0] int_en;
   logic protect; // access protection unit lock
   logic bod_rst_en;
   logic [N-1:0] rdy_d; // previous ready, for rise detect

   // =====================================================================
   // run decision
   // =====================================================================
   // settings in, one run bit per oscillator out
   osr_run_if #(.N(N)) rif ();
   assign rif.enable = en_r;
   assign rif.run_on_request = od_r;
   assign rif.run_in_standby = sb_r;
   assign rif.request = req_s2;
   assign rif.mode = mode_s2;

   osr_run_decide u_decide (
      .rif(rif)
   );

   // =====================================================================
   // axi write channel
   // =====================================================================
   // address and data are latched independently, so either may come first
   // the readies are flops; a low ready marks a held item
   wire aw_held = !s_axi_awready;
   wire w_held = !s_axi_wready;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   wire do_write = aw_held && w_held && !s_axi_bvalid;
   wire [7:0] wr_off = aw_addr & 8'hfc;
   wire wr_osc = (wr_off < OSR_OFF_PLL_REF) && ((wr_off >> 2) < 8'(N));
   wire [2:0] wr_idx = 3'(wr_off >> 2);
   wire wr_flags = (wr_off == OSR_OFF_INT_FLAGS);
   wire wr_known = wr_osc || wr_flags || wr_off == OSR_OFF_PLL_REF || wr_off == OSR_OFF_INT_ENABLE
      || wr_off == OSR_OFF_PROTECT || wr_off == OSR_OFF_BOD_CTRL;
   // lock is lifted under debug halt or for debugger accesses; flags never locked
   wire locked = protect && !halted && !dbg_acc;
   wire wr_ok = do_write && w_strb[0]
      && (!locked || wr_flags);
   // locked writes and holes get an error
   wire wr_slverr = !wr_known || (locked && !wr_flags);
   // write one clears, zero keeps
   wire [N-1:0] flag_clr = (wr_ok && wr_flags) ? w_data[N-1:0] : '0;
   // a ready rise sets its flag
   wire [N-1:0] rdy_rise = rdy_s2 & ~rdy_d;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= OSR_RESP_OKAY;
      end else begin
         // a taken item is held until the response goes out
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_slverr ? OSR_RESP_SLVERR : OSR_RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // =====================================================================
   // register updates
   // =====================================================================
   // only byte lane 0 carries fields (divider in lane 1 also gated on lane 0)
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_r <= '0;
         od_r <= '1;
         sb_r <= '0;
         xtal_r <= '0;
         ref_sel_r <= OSR_REF_XTAL_32K;
         ref_div_r <= 8'h00;
         int_en <= '0;
         protect <= 1'b0;
         bod_rst_en <= 1'b1;
      end else if (wr_ok) begin
         if (wr_osc) begin
            en_r[wr_idx] <= w_data[OSR_BIT_ENABLE];
            od_r[wr_idx] <= w_data[OSR_BIT_RUN_ON_REQUEST];
            sb_r[wr_idx] <= w_data[OSR_BIT_RUN_IN_STANDBY];
            xtal_r[wr_idx] <= w_data[OSR_BIT_XTAL_MODE];
         end
         // the spare select code is ignored
         if (wr_off == OSR_OFF_PLL_REF && w_data[1:0] <= OSR_REF_GENERIC) begin
            ref_sel_r <= w_data[1:0];
            ref_div_r <= w_data[OSR_REF_DIV_LSB +: OSR_REF_DIV_W];
         end
         if (wr_off == OSR_OFF_INT_ENABLE) int_en <= w_data[N-1:0];
         if (wr_off == OSR_OFF_PROTECT) protect <= w_data[0];
         if (wr_off == OSR_OFF_BOD_CTRL) bod_rst_en <= w_data[OSR_BIT_BOD_RESET_EN];
      end
   end

   // flags: a rising ready wins over a simultaneous clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdy_d <= '0;
         flags <= '0;
      end else begin
         rdy_d <= rdy_s2;
         flags <= (flags & ~flag_clr) | rdy_rise;
      end
   end

   // =====================================================================
   // axi read channel
   // =====================================================================
   wire [7:0] rd_off = s_axi_araddr & 8'hfc;
   wire rd_osc = (rd_off < OSR_OFF_PLL_REF) && ((rd_off >> 2) < 8'(N));
   wire [2:0] rd_idx = 3'(rd_off >> 2);

   logic [31:0] rd_val;
   logic rd_err;

   // read mux, one word per offset
   always_comb begin
      rd_val = 32'h0;
      rd_err = 1'b0;
      if (rd_osc) begin
         rd_val[OSR_BIT_ENABLE] = en_r[rd_idx];
         rd_val[OSR_BIT_RUN_ON_REQUEST] = od_r[rd_idx];
         rd_val[OSR_BIT_RUN_IN_STANDBY] = sb_r[rd_idx];
         rd_val[OSR_BIT_XTAL_MODE] = xtal_r[rd_idx];
      end else begin
         case (rd_off)
            OSR_OFF_PLL_REF: begin
               rd_val[1:0] = ref_sel_r;
               rd_val[OSR_REF_DIV_LSB +: OSR_REF_DIV_W] = ref_div_r;
            end
            OSR_OFF_RUN_STATUS: rd_val[N-1:0] = rif.run; // shows live run state
            OSR_OFF_INT_FLAGS: rd_val[N-1:0] = flags;
            OSR_OFF_INT_ENABLE: rd_val[N-1:0] = int_en;
            OSR_OFF_PROTECT: rd_val[0] = protect;
            OSR_OFF_BOD_CTRL: rd_val[OSR_BIT_BOD_RESET_EN] = bod_rst_en;
            default: rd_err = 1'b1;
         endcase
      end
   end

   // read answer registered; arready low while it stands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= OSR_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_arready <= 1'b0;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_err ? OSR_RESP_SLVERR : OSR_RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // =====================================================================
   // async domain enable crossing
   // =====================================================================
   // enables into the loop / sampled-brownout domain pass two flops there;
   // no debug freeze anywhere, everything keeps clocking
   logic [N-1:0] as_s1, as_s2;

   always_ff @(posedge async_domain_clk) begin
      if (!aresetn) begin
         as_s1 <= '0;
         as_s2 <= '0;
      end else begin
         as_s1 <= en_r;
         as_s2 <= as_s1;
      end
   end

   // =====================================================================
   // registered outputs
   // =====================================================================
   // every output leaves from a flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_run <= '0;
         main_osc_input_pin_own <= 1'b0;
         main_osc_output_pin_own <= 1'b0;
         slow_osc_input_pin_own <= 1'b0;
         slow_osc_output_pin_own <= 1'b0;
         pll_ref_select <= OSR_REF_XTAL_32K;
         pll_ref_divider <= 8'h00;
         brownout_3v3_reset <= 1'b0;
         irq <= 1'b0;
         wake_request <= 1'b0;
      end else begin
         osc_run <= rif.run;
         // pins taken whenever enabled; output pin only in crystal mode
         main_osc_input_pin_own <= en_r[OSR_IDX_MAIN_XTAL];
         main_osc_output_pin_own <= en_r[OSR_IDX_MAIN_XTAL] && xtal_r[OSR_IDX_MAIN_XTAL];
         slow_osc_input_pin_own <= en_r[OSR_IDX_XTAL_32K];
         slow_osc_output_pin_own <= en_r[OSR_IDX_XTAL_32K] && xtal_r[OSR_IDX_XTAL_32K];
         pll_ref_select <= ref_sel_r;
         pll_ref_divider <= ref_div_r;
         brownout_3v3_reset <= bod_req && bod_rst_en && !cold_plug;
         irq <= |(flags & int_en);
         wake_request <= |(flags & int_en);
      end
   end
   // already a flop of the far domain
   assign async_enable = as_s2;
endmodule : osr_ctrl

// [rtl/osr_pkg.sv]
package osr_pkg;
   // =====================================================================
   // oscillator indices
   // =====================================================================
   localparam int OSR_NUM_OSC = 7;
   localparam int OSR_IDX_MAIN_XTAL = 0;
   localparam int OSR_IDX_XTAL_32K = 1;
   localparam int OSR_IDX_INT_32K = 2;
   localparam int OSR_IDX_ULP_32K = 3;
   localparam int OSR_IDX_INT_8M = 4;
   localparam int OSR_IDX_FLL = 5;
   localparam int OSR_IDX_PLL = 6;
   // =====================================================================
   // register byte offsets (all chosen, word aligned)
   // =====================================================================
   localparam logic [7:0] OSR_OFF_OSC_CTRL_BASE = 8'h00; // one word per oscillator, 0x00..0x18
   localparam logic [7:0] OSR_OFF_PLL_REF = 8'h20;
   localparam logic [7:0] OSR_OFF_RUN_STATUS = 8'h24;
   localparam logic [7:0] OSR_OFF_INT_FLAGS = 8'h28;
   localparam logic [7:0] OSR_OFF_INT_ENABLE = 8'h2c;
   localparam logic [7:0] OSR_OFF_PROTECT = 8'h30;
   localparam logic [7:0] OSR_OFF_BOD_CTRL = 8'h34;
   // =====================================================================
   // oscillator control word fields
   // =====================================================================
   localparam int OSR_BIT_ENABLE = 1;
   localparam int OSR_BIT_RUN_IN_STANDBY = 6;
   localparam int OSR_BIT_RUN_ON_REQUEST = 7;
   localparam int OSR_BIT_XTAL_MODE = 2;
   localparam logic [2:0] OSR_CTRL_RESET = 3'h4; // {run_on_request, run_in_standby, enable}
   // pll reference field: bits 1:0 select, bits 15:8 divider
   localparam logic [1:0] OSR_REF_XTAL_32K = 2'h0;
   localparam logic [1:0] OSR_REF_MAIN_XTAL = 2'h1;
   localparam logic [1:0] OSR_REF_GENERIC = 2'h2;
   localparam int OSR_REF_DIV_LSB = 8;
   localparam int OSR_REF_DIV_W = 8;
   // bod control: bit 0 = brownout 3v3 reset enable
   localparam int OSR_BIT_BOD_RESET_EN = 0;
   // =====================================================================
   // sleep modes and bus answers
   // =====================================================================
   typedef enum logic [1:0] {
      OSR_MODE_ACTIVE = 2'b00,
      OSR_MODE_IDLE = 2'b01,
      OSR_MODE_STANDBY = 2'b10
   } osr_mode_t;
   localparam logic [1:0] OSR_RESP_OKAY = 2'h0;
   localparam logic [1:0] OSR_RESP_SLVERR = 2'h2;
endpackage : osr_pkg

// [rtl/osr_run_decide.sv]
`timescale 1ns/1ps
// =====================================================================
// per-oscillator run decision, purely combinational
// =====================================================================
module osr_run_decide
   import osr_pkg::*;
(
   osr_run_if.decide rif
);
   // standby override is not honoured by the loops
   function automatic logic osr_standby_capable(input int idx);
      return !(idx == OSR_IDX_FLL || idx == OSR_IDX_PLL);
   endfunction : osr_standby_capable

   for (genvar i = 0; i < OSR_NUM_OSC; i++) begin : g_osc
      wire en = rif.enable[i];
      wire od = rif.run_on_request[i];
      wire sb = rif.run_in_standby[i] && osr_standby_capable(i);
      wire req = rif.request[i];
      wire in_standby = (rif.mode == OSR_MODE_STANDBY);
      // active and idle: on-demand gates on request, else runs
      wire idle_run = en && (!od || req);
      // standby: stop unless run_in_standby; then request-gated or forced
      wire stby_run = en && sb && (!od || req);
      if (i == OSR_IDX_ULP_32K) begin : g_ulp
         assign rif.run[i] = 1'b1;
      end else begin : g_norm
         assign rif.run[i] = in_standby ? stby_run : idle_run;
      end
   end
endmodule : osr_run_decide

// [rtl/osr_run_if.sv]
`timescale 1ns/1ps
// carries the per-oscillator settings to the run decision and the results back
interface osr_run_if #(parameter int N = 7);
   logic [N-1:0] enable;
   logic [N-1:0] run_on_request;
   logic [N-1:0] run_in_standby;
   logic [N-1:0] request;
   logic [1:0] mode;
   logic [N-1:0] run;
   modport ctrl (output enable, output run_on_request, output run_in_standby, output request, output mode,
      input run);
   modport decide (input enable, input run_on_request, input run_in_standby, input request, input mode,
      output run);
endinterface : osr_run_if
